// *** cad_alu_datapath.v ***
/*
 * byte/word arithmetic, logic, multiply, des round and indirect jumps,
 * with the status flags, extended jump register and pc held here.
 * assumes the decoder offers one operation at a time, waits for
 * op_ready, and writes the returned results into the register file.
 */
`include "cad_defines.vh"
module cad_alu_datapath (
   input  wire         clk,          // core clock
   input  wire         reset,        // synchronous reset, high
   input  wire         op_valid,     // operation offered
   input  wire [4:0]   op_code,      // operation code
   input  wire [7:0]   op_a,         // destination operand
   input  wire [7:0]   op_b,         // source register or constant
   input  wire [15:0]  word_in,      // register pair for word ops
   input  wire [15:0]  z_ptr,        // z pointer
   input  wire [127:0] des_in,       // registers fifteen to zero
   output wire         op_ready,     // operation may be taken
   output reg          res_valid,    // result pulse
   output reg  [1:0]   res_kind,     // 0 byte 1 word 2 pair one:zero 3 des
   output reg  [15:0]  res_data,     // byte or word result
   output reg  [127:0] des_out,      // des block result
   output reg  [21:0]  pc,           // program counter
   output reg          pc_load,      // pc loaded pulse
   output reg  [5:0]   flags,        // status flags
   input  wire [7:0]   bus_addr,     // register address
   input  wire [31:0]  bus_wdata,    // write data
   input  wire         bus_wr,       // write strobe
   input  wire         bus_rd,       // read strobe
   output reg  [31:0]  bus_rdata     // read data, cycle after strobe
);
   localparam ST_IDLE = 1'b0;
   localparam ST_WAIT = 1'b1;

   reg          state;
   reg  [5:0]   ext_ind;
   reg          last_des;
   reg  [5:0]   pend_flags;
   reg  [15:0]  pend_data;
   reg  [1:0]   pend_kind;
   reg  [127:0] pend_des;
   reg          pend_jump;
   reg  [21:0]  pend_pc;

   reg  [5:0]   next_flags;
   reg  [15:0]  next_data;
   reg  [1:0]   next_kind;
   reg          next_two;
   reg          next_jump;
   reg  [21:0]  next_pc;
   reg  [7:0]   r8;
   reg  [15:0]  r16;
   reg  [15:0]  prod;
   reg          sub_op;
   reg          cin;

   wire         take;
   wire         f_c;
   wire         f_h;
   wire [5:0]   flags_bus;
   wire [63:0]  des_round_out;

   // ***************************************
   // helpers
   // ***************************************
   function is_two_cycle;
      input [4:0] code;
      input       prev_des;
      begin
         case (code)
            `CAD_OP_WADD, `CAD_OP_WSUB, `CAD_OP_MUL, `CAD_OP_MULS,
            `CAD_OP_MULMIX, `CAD_OP_FMUL, `CAD_OP_FMULS, `CAD_OP_FMULMIX,
            `CAD_OP_JIND, `CAD_OP_JEXT: is_two_cycle = 1'b1;
            `CAD_OP_DES: is_two_cycle = ~prev_des;
            default: is_two_cycle = 1'b0;
         endcase
      end
   endfunction

   function [5:0] logic_flags;
      input [5:0] old;
      input [7:0] res;
      reg   [5:0] f;
      begin
         f = old;
         f[`CAD_F_Z] = (res == 8'h00);
         f[`CAD_F_N] = res[7];
         f[`CAD_F_V] = 1'b0;
         f[`CAD_F_S] = res[7];
         logic_flags = f;
      end
   endfunction

   // ***************************************
   // des round
   // ***************************************
   cad_des_round u_des (
      .block_in  (des_in[63:0]),
      .key_in    (des_in[127:64]),
      .round     (op_b[3:0]),
      .decrypt   (f_h),                                    // RL10
      .block_out (des_round_out)
   );

   assign take     = op_valid & op_ready;
   assign op_ready = (state == ST_IDLE);
   assign f_c      = flags_bus[`CAD_F_C];
   assign f_h      = flags_bus[`CAD_F_H];
   // software write seen by the same-cycle operation
   assign flags_bus = (bus_wr && bus_addr == `CAD_REG_FLAGS) ? bus_wdata[5:0] : flags;

   // ***************************************
   // operation decode and compute
   // ***************************************
   always @* begin
      next_flags = flags_bus;                                 // RL13
      next_data  = 16'h0000;
      next_kind  = 2'h0;
      next_jump  = 1'b0;
      next_pc    = pc;
      r8         = 8'h00;
      r16        = 16'h0000;
      prod       = 16'h0000;
      sub_op     = 1'b0;
      cin        = 1'b0;
      next_two   = is_two_cycle(op_code, last_des);
      case (op_code)
         `CAD_OP_ADD, `CAD_OP_ADC, `CAD_OP_SUB, `CAD_OP_SBC: begin
            sub_op = (op_code == `CAD_OP_SUB) || (op_code == `CAD_OP_SBC);
            cin = f_c & ((op_code == `CAD_OP_ADC) || (op_code == `CAD_OP_SBC)); // RL3
            r8  = sub_op ? (op_a - op_b - {7'h00, cin}) : (op_a + op_b + {7'h00, cin}); // RL3
            next_data = {8'h00, r8};
            if (sub_op) begin
               next_flags[`CAD_F_H] = (~op_a[3] & op_b[3]) | (op_b[3] & r8[3]) | (r8[3] & ~op_a[3]);
               next_flags[`CAD_F_C] = (~op_a[7] & op_b[7]) | (op_b[7] & r8[7]) | (r8[7] & ~op_a[7]);
               next_flags[`CAD_F_V] = (op_a[7] & ~op_b[7] & ~r8[7]) | (~op_a[7] & op_b[7] & r8[7]);
            end else begin
               next_flags[`CAD_F_H] = (op_a[3] & op_b[3]) | (op_b[3] & ~r8[3]) | (~r8[3] & op_a[3]);
               next_flags[`CAD_F_C] = (op_a[7] & op_b[7]) | (op_b[7] & ~r8[7]) | (~r8[7] & op_a[7]);
               next_flags[`CAD_F_V] = (op_a[7] & op_b[7] & ~r8[7]) | (~op_a[7] & ~op_b[7] & r8[7]);
            end
            // with borrow, zero only stays set across the chain
            if (op_code == `CAD_OP_SBC)
               next_flags[`CAD_F_Z] = (r8 == 8'h00) & flags_bus[`CAD_F_Z];
            else
               next_flags[`CAD_F_Z] = (r8 == 8'h00);
            next_flags[`CAD_F_N] = r8[7];
            next_flags[`CAD_F_S] = r8[7] ^ next_flags[`CAD_F_V];
         end
         `CAD_OP_WADD, `CAD_OP_WSUB: begin
            if (op_code == `CAD_OP_WADD) begin
               r16 = word_in + {10'h000, op_b[5:0]};                         // RL1
               next_flags[`CAD_F_V] = ~word_in[15] & r16[15];
               next_flags[`CAD_F_C] = ~r16[15] & word_in[15];
            end else begin
               r16 = word_in - {10'h000, op_b[5:0]};                         // RL2
               next_flags[`CAD_F_V] = word_in[15] & ~r16[15];
               next_flags[`CAD_F_C] = r16[15] & ~word_in[15];
            end
            next_flags[`CAD_F_Z] = (r16 == 16'h0000);
            next_flags[`CAD_F_N] = r16[15];
            next_flags[`CAD_F_S] = r16[15] ^ next_flags[`CAD_F_V];
            next_data = r16;
            next_kind = 2'h1;
         end
         `CAD_OP_AND, `CAD_OP_OR, `CAD_OP_EOR, `CAD_OP_SETB, `CAD_OP_CLRB, `CAD_OP_TEST: begin
            case (op_code)
               `CAD_OP_AND:  r8 = op_a & op_b;                               // RL4
               `CAD_OP_OR:   r8 = op_a | op_b;                               // RL4
               `CAD_OP_EOR:  r8 = op_a ^ op_b;                               // RL4
               `CAD_OP_SETB: r8 = op_a | op_b;                               // RL5
               `CAD_OP_CLRB: r8 = op_a & (8'hff - op_b);                     // RL6
               default:      r8 = op_a & op_a;                               // RL7
            endcase
            next_flags = logic_flags(flags_bus, r8);                         // RL4
            next_data  = {8'h00, r8};
         end
         `CAD_OP_MUL, `CAD_OP_MULS, `CAD_OP_MULMIX,
         `CAD_OP_FMUL, `CAD_OP_FMULS, `CAD_OP_FMULMIX: begin
            case (op_code)
               `CAD_OP_MULS, `CAD_OP_FMULS:
                  prod = {{8{op_a[7]}}, op_a} * {{8{op_b[7]}}, op_b};       // RL8
               `CAD_OP_MULMIX, `CAD_OP_FMULMIX:
                  prod = {{8{op_a[7]}}, op_a} * {8'h00, op_b};              // RL8
               default:
                  prod = {8'h00, op_a} * {8'h00, op_b};                     // RL8
            endcase
            next_flags[`CAD_F_C] = prod[15];
            if (op_code == `CAD_OP_FMUL || op_code == `CAD_OP_FMULS || op_code == `CAD_OP_FMULMIX)
               next_data = {prod[14:0], 1'b0};                               // RL9
            else
               next_data = prod;
            next_flags[`CAD_F_Z] = (next_data == 16'h0000);                  // RL8
            next_kind = 2'h2;
         end
         `CAD_OP_DES: begin
            next_kind = 2'h3;                                                // RL10
         end
         `CAD_OP_JIND: begin
            next_jump = 1'b1;
            next_pc   = {6'h00, z_ptr};                                      // RL11
         end
         `CAD_OP_JEXT: begin
            next_jump = 1'b1;
            next_pc   = {ext_ind, z_ptr};                                    // RL12
         end
         default: begin
            next_flags = flags_bus;
         end
      endcase
   end

   // ***************************************
   // sequencing and commit
   // ***************************************
   always @(posedge clk) begin
      if (reset) begin
         state      <= ST_IDLE;
         flags      <= `CAD_FLAGS_RST;
         pc         <= `CAD_PC_RST;
         ext_ind    <= `CAD_EXTIND_RST;
         last_des   <= 1'b0;
         res_valid  <= 1'b0;
         res_kind   <= 2'h0;
         res_data   <= 16'h0000;
         des_out    <= 128'h0;
         pc_load    <= 1'b0;
         pend_flags <= `CAD_FLAGS_RST;
         pend_data  <= 16'h0000;
         pend_kind  <= 2'h0;
         pend_des   <= 128'h0;
         pend_jump  <= 1'b0;
         pend_pc    <= `CAD_PC_RST;
      end else begin
         res_valid <= 1'b0;
         pc_load   <= 1'b0;
         // software writes first; a completing operation overrides a flags write, never an ext_ind write
         if (bus_wr && bus_addr == `CAD_REG_FLAGS)
            flags <= bus_wdata[5:0];
         if (bus_wr && bus_addr == `CAD_REG_EXTIND)
            ext_ind <= bus_wdata[5:0];
         case (state)
            ST_IDLE: begin
               if (take) begin
                  last_des <= (op_code == `CAD_OP_DES);
                  if (next_two) begin
                     state      <= ST_WAIT;                                  // RL1
                     pend_flags <= next_flags;
                     pend_data  <= next_data;
                     pend_kind  <= next_kind;
                     pend_des   <= {des_in[127:64], des_round_out};
                     pend_jump  <= next_jump;
                     pend_pc    <= next_pc;
                  end else begin
                     flags     <= next_flags;                                // RL3
                     res_valid <= 1'b1;
                     res_kind  <= next_kind;
                     res_data  <= next_data;
                     des_out   <= {des_in[127:64], des_round_out};
                  end
               end
            end
            ST_WAIT: begin
               state <= ST_IDLE;
               flags <= pend_flags;                                          // RL2
               if (pend_jump) begin
                  pc      <= pend_pc;                                        // RL11
                  pc_load <= 1'b1;
               end else begin
                  res_valid <= 1'b1;                                         // RL8
                  res_kind  <= pend_kind;
                  res_data  <= pend_data;
                  des_out   <= pend_des;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************
   // register read port
   // ***************************************
   always @(posedge clk) begin
      if (reset) begin
         bus_rdata <= 32'h00000000;
      end else if (bus_rd) begin
         case (bus_addr)
            `CAD_REG_FLAGS:  bus_rdata <= {26'h0000000, flags};
            `CAD_REG_EXTIND: bus_rdata <= {26'h0000000, ext_ind};
            `CAD_REG_PCLO:   bus_rdata <= {16'h0000, pc[15:0]};
            `CAD_REG_PCHI:   bus_rdata <= {26'h0000000, pc[21:16]};
            default:         bus_rdata <= 32'h00000000;
         endcase
      end else begin
         bus_rdata <= 32'h00000000;
      end
   end
endmodule // cad_alu_datapath

// *** cad_defines.vh ***
/*
 * opcode codes, flag bit positions, register offsets and reset values
 * of the execution datapath; assumes inclusion by bare name only.
 */
// Operation
// RL1 - word add immediate: pair plus constant, flags ZCNVS, two cycles
// RL2 - word subtract immediate: pair minus constant, flags ZCNVS, two cycles
// RL3 - byte add/subtract, optional carry, one cycle, flags ZCNVSH
// RL4 - and/or/xor register or immediate, one cycle, flags ZNVS only
// RL5 - set bits: destination or mask, one cycle, flags ZNVS
// RL6 - clear bits: destination and inverted mask, one cycle, flags ZNVS
// RL7 - test: register and itself, one cycle, flags ZNVS
// RL8 - integer multiply uu/ss/su into pair one:zero, two cycles, flags ZC
// RL9 - fractional multiply, product shifted left one, two cycles, flags ZC
// RL10 - des round: encrypt when half-carry clear, decrypt when set, 1/2 cycles
// RL11 - indirect jump: pc low from pointer, upper bits cleared, two cycles
// RL12 - extended jump: pc low from pointer, upper from extended register
// RL13 - flags not affected by an operation keep their value
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH
// opcodes
`define CAD_OP_ADD     5'h00
`define CAD_OP_ADC     5'h01
`define CAD_OP_SUB     5'h02
`define CAD_OP_SBC     5'h03
`define CAD_OP_WADD    5'h04
`define CAD_OP_WSUB    5'h05
`define CAD_OP_AND     5'h06
`define CAD_OP_OR      5'h07
`define CAD_OP_EOR     5'h08
`define CAD_OP_SETB    5'h09
`define CAD_OP_CLRB    5'h0a
`define CAD_OP_TEST    5'h0b
`define CAD_OP_MUL     5'h0c
`define CAD_OP_MULS    5'h0d
`define CAD_OP_MULMIX  5'h0e
`define CAD_OP_FMUL    5'h0f
`define CAD_OP_FMULS   5'h10
`define CAD_OP_FMULMIX 5'h11
`define CAD_OP_DES     5'h12
`define CAD_OP_JIND    5'h13
`define CAD_OP_JEXT    5'h14
// flag bit positions
`define CAD_F_C        0
`define CAD_F_Z        1
`define CAD_F_N        2
`define CAD_F_V        3
`define CAD_F_S        4
`define CAD_F_H        5
// register offsets
`define CAD_REG_FLAGS  8'h00
`define CAD_REG_EXTIND 8'h04
`define CAD_REG_PCLO   8'h08
`define CAD_REG_PCHI   8'h0c
// reset values
`define CAD_FLAGS_RST  6'h00
`define CAD_EXTIND_RST 6'h00
`define CAD_PC_RST     22'h000000
`endif

// *** cad_des_round.v ***
/*
 * one feistel round over the 64-bit data half of the des block.
 * assumes key and round index stay steady while the result is used.
 */
module cad_des_round (
   input  wire [63:0] block_in,   // data registers zero to seven
   input  wire [63:0] key_in,     // key registers eight to fifteen
   input  wire [3:0]  round,      // round index
   input  wire        decrypt,    // high for inverse round
   output wire [63:0] block_out   // data after the round
);
   wire [31:0] left;
   wire [31:0] right;
   wire [31:0] subkey;
   wire [31:0] f_in;
   wire [31:0] f_out;
   wire [5:0]  rot;

   // ***************************************
   // round function
   // ***************************************
   assign left   = block_in[63:32];
   assign right  = block_in[31:0];
   assign rot    = {1'b0, round, 1'b0};
   assign subkey = key_in[31:0] ^ (key_in[63:32] << rot[4:0]) ^ (key_in[63:32] >> (6'h20 - rot));
   assign f_in   = decrypt ? left : right;
   assign f_out  = {f_in[26:0], f_in[31:27]} ^ subkey ^ {f_in[3:0], f_in[31:4]};

   // decrypt undoes encrypt for the same round and key
   assign block_out = decrypt ? {right ^ f_out, left} : {right, left ^ f_out};
endmodule // cad_des_round

// *** cad_alu_props.sv ***
/* timing and flag checks on the datapath ports;
   assumes the bench writes no flags while an operation runs */
`include "cad_defines.vh"
module cad_alu_props (
   input logic         clk,       // clock
   input logic         reset,     // reset
   input logic         op_valid,  // offer
   input logic         op_ready,  // idle
   input logic [4:0]   op_code,   // code
   input logic [7:0]   op_a,      // rd
   input logic [7:0]   op_b,      // rr
   input logic [15:0]  z_ptr,     // z
   input logic         bus_wr,    // write
   input logic         res_valid, // result
   input logic [1:0]   res_kind,  // kind
   input logic [15:0]  res_data,  // data
   input logic [21:0]  pc,        // pc
   input logic         pc_load,   // jump
   input logic [5:0]   flags      // status
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic tk, wd, ml, lg, jp;
   assign tk = op_valid && op_ready;
   assign wd = op_code == `CAD_OP_WADD || op_code == `CAD_OP_WSUB;
   assign ml = op_code >= `CAD_OP_MUL && op_code <= `CAD_OP_FMULMIX;
   assign lg = op_code >= `CAD_OP_AND && op_code <= `CAD_OP_TEST;
   assign jp = op_code == `CAD_OP_JIND || op_code == `CAD_OP_JEXT;
   property p_byte;
      tk && (op_code <= `CAD_OP_SBC || lg) |=> res_valid && res_kind == 2'h0;
   endproperty
   a_byte: assert property (p_byte) else $error("byte op late");
   property p_two;
      tk && (wd || ml) |=> !op_ready && !res_valid ##1 res_valid;
   endproperty
   a_two: assert property (p_two) else $error("two cycle op timing");
   property p_add;
      tk && op_code == `CAD_OP_ADD |=> res_data[7:0] == $past(op_a) + $past(op_b);
   endproperty
   a_add: assert property (p_add) else $error("add sum wrong");
   property p_logic;
      tk && lg && !bus_wr |=> $stable(flags[`CAD_F_C]) && $stable(flags[`CAD_F_H]);
   endproperty
   a_logic: assert property (p_logic) else $error("logic op moved carry");
   property p_wordh;
      tk && wd && !bus_wr ##1 !bus_wr |=> flags[`CAD_F_H] == $past(flags[`CAD_F_H], 2);
   endproperty
   a_wordh: assert property (p_wordh) else $error("word op moved half carry");
   property p_mulk;
      tk && ml && !bus_wr ##1 !bus_wr |=> flags[5:2] == $past(flags[5:2], 2);
   endproperty
   a_mulk: assert property (p_mulk) else $error("multiply moved flags");
   property p_mul;
      tk && op_code == `CAD_OP_MUL |-> ##2 res_kind == 2'h2 && res_data == $past(op_a, 2) * $past(op_b, 2);
   endproperty
   a_mul: assert property (p_mul) else $error("product wrong");
   property p_jind;
      tk && op_code == `CAD_OP_JIND |-> ##2 pc_load && pc == {6'h00, $past(z_ptr, 2)};
   endproperty
   a_jind: assert property (p_jind) else $error("indirect jump pc wrong");
   property p_jext;
      tk && op_code == `CAD_OP_JEXT |-> ##2 pc_load && pc[15:0] == $past(z_ptr, 2);
   endproperty
   a_jext: assert property (p_jext) else $error("extended jump pc wrong");
   property p_jflg;
      tk && jp && !bus_wr ##1 !bus_wr |=> flags == $past(flags, 2);
   endproperty
   a_jflg: assert property (p_jflg) else $error("jump moved flags");
   c_mul: cover property (tk && ml);
   c_jmp: cover property (pc_load);
   c_des: cover property (tk && op_code == `CAD_OP_DES);
endmodule // cad_alu_props
bind cad_alu_datapath cad_alu_props u_props (.clk(clk), .reset(reset), .op_valid(op_valid),
   .op_ready(op_ready), .op_code(op_code), .op_a(op_a), .op_b(op_b), .z_ptr(z_ptr), .bus_wr(bus_wr),
   .res_valid(res_valid), .res_kind(res_kind), .res_data(res_data), .pc(pc), .pc_load(pc_load), .flags(flags));

// *** cad_dec_model.sv ***
/* decoder and register file side: offers one operation, waits for
   its result; assumes the datapath is idle when an offer starts */
module cad_dec_model (
   input  logic         clk,       // clock
   input  logic         op_ready,  // idle
   input  logic         res_valid, // result
   input  logic         pc_load,   // jump done
   output logic         op_valid,  // offer
   output logic [4:0]   op_code,   // code
   output logic [7:0]   op_a,      // rd
   output logic [7:0]   op_b,      // rr or k
   output logic [15:0]  word_in,   // pair
   output logic [15:0]  z_ptr,     // z
   output logic [127:0] des_in     // r15..r0
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      op_valid = 1'b0;
      op_code = 5'h00;
      {op_a, op_b, word_in, z_ptr, des_in} = '0;
   end
   task automatic issue(input logic [4:0] c, input logic [7:0] a, input logic [7:0] b,
                        input logic [15:0] w, input logic [15:0] z, input logic [127:0] d, output int n);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= c;
      {op_a, op_b, word_in, z_ptr, des_in} <= {a, b, w, z, d};
      @(posedge clk);
      while (!op_ready)
         @(posedge clk);
      op_valid <= 1'b0;
      // released operands no longer hold their value
      {op_a, op_b, word_in, z_ptr, des_in} <= ~{a, b, w, z, d};
      n = 1;
      #1;
      while (!(res_valid | pc_load) && n < 6) begin
         @(posedge clk);
         n++;
         #1;
      end
   endtask
endmodule // cad_dec_model

// *** cad_alu_datapath_test.sv ***
/* self-checking bench for the datapath; the decoder model offers
   operations, the bench itself is the register port master */
`include "cad_defines.vh"
module cad_alu_datapath_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, bus_wr, bus_rd, op_valid, op_ready, res_valid, pc_load;
   logic [4:0] op_code;
   logic [7:0] bus_addr, op_a, op_b;
   logic [31:0] bus_wdata, bus_rdata, d;
   logic [15:0] word_in, z_ptr, res_data;
   logic [127:0] des_in, des_out, y;
   logic [1:0] res_kind;
   logic [21:0] pc;
   logic [5:0] flags;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   // code a b word result flags
   logic [63:0] tab [23] = '{
      64'h00_7f_01_0000_0080_2c, 64'h02_00_01_0000_00ff_35, 64'h06_f0_3c_0000_0030_21,
      64'h09_01_80_0000_0081_35, 64'h03_05_04_0000_0000_00, 64'h02_05_05_0000_0000_02,
      64'h03_00_00_0000_0000_02, 64'h0a_ff_0f_0000_00f0_14, 64'h0b_00_00_0000_0000_02,
      64'h08_5a_a5_0000_00ff_14, 64'h07_00_00_0000_0000_02, 64'h00_ff_01_0000_0000_23,
      64'h01_10_20_0000_0031_00, 64'h04_00_01_ffff_0000_23, 64'h05_00_3f_0000_ffc1_35,
      64'h04_00_01_7fff_8000_2c, 64'h0c_ff_ff_0000_fe01_3d, 64'h0d_ff_ff_0000_0001_3c,
      64'h0e_ff_02_0000_fffe_3d, 64'h0f_80_80_0000_8000_3c, 64'h10_80_80_0000_8000_3c,
      64'h11_ff_80_0000_ff00_3d, 64'h0c_00_55_0000_0000_3e};
   cad_alu_datapath DUT (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code), .op_a(op_a),
      .op_b(op_b), .word_in(word_in), .z_ptr(z_ptr), .des_in(des_in), .op_ready(op_ready),
      .res_valid(res_valid), .res_kind(res_kind), .res_data(res_data), .des_out(des_out), .pc(pc),
      .pc_load(pc_load), .flags(flags), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   cad_dec_model dec (.clk(clk), .op_ready(op_ready), .res_valid(res_valid), .pc_load(pc_load),
      .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .word_in(word_in),
      .z_ptr(z_ptr), .des_in(des_in));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      v = bus_rdata;
   endtask
   task automatic test_ops;
      logic [63:0] t;
      logic [1:0] k;
      bus_write(`CAD_REG_FLAGS, 32'h00);
      for (int i = 0; i < 23; i++) begin
         t = tab[i];
         if (i == 13) bus_write(`CAD_REG_FLAGS, 32'h20);
         if (i == 16) bus_write(`CAD_REG_FLAGS, 32'h3c);
         k = (t[60:56] == `CAD_OP_WADD || t[60:56] == `CAD_OP_WSUB) ? 2'h1 : (t[60:56] >= `CAD_OP_MUL) ? 2'h2 : 2'h0;
         dec.issue(t[60:56], t[55:48], t[47:40], t[39:24], 16'h0000, 128'h0, n);
         check(n, (k == 2'h0) ? 1 : 2);
         check((k == 2'h0) ? {8'h00, res_data[7:0]} : res_data, t[23:8]);
         check(res_kind, k);
         check(flags, t[5:0]);
      end
   endtask
   task automatic test_jump;
      bus_write(`CAD_REG_EXTIND, 32'h2a);
      bus_read(`CAD_REG_EXTIND, d);
      check(d, 32'h2a);
      bus_write(`CAD_REG_FLAGS, 32'h15);
      dec.issue(`CAD_OP_JEXT, 8'h00, 8'h00, 16'h0000, 16'habcd, 128'h0, n);
      check(n, 2);
      check(pc, 22'h2aabcd);
      dec.issue(`CAD_OP_JIND, 8'h00, 8'h00, 16'h0000, 16'h1234, 128'h0, n);
      check(n, 2);
      check(pc, 22'h001234);
      check(flags, 6'h15);
      bus_write(`CAD_REG_PCLO, 32'hffff);
      bus_read(`CAD_REG_PCLO, d);
      check(d, 32'h1234);
      bus_read(`CAD_REG_PCHI, d);
      check(d, 32'h0);
      bus_read(8'h10, d);
      check(d, 32'h0);
   endtask
   task automatic test_des;
      bus_write(`CAD_REG_FLAGS, 32'h00);
      dec.issue(`CAD_OP_DES, 8'h00, 8'h03, 16'h0, 16'h0, 128'h0f1e2d3c4b5a6978_8796a5b4c3d2e1f0, n);
      check(n, 2);
      check(des_out[127:64], 64'h0f1e2d3c4b5a6978);
      y = des_out;
      bus_write(`CAD_REG_FLAGS, 32'h20);
      dec.issue(`CAD_OP_DES, 8'h00, 8'h03, 16'h0, 16'h0, y, n);
      check(n, 1);
      check(res_kind, 2'h3);
      check(des_out[63:0], 64'h8796a5b4c3d2e1f0);
   endtask
   task automatic test_done;
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      test_done;
   end
   initial begin
      reset = 1'b1;
      {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      #1;
      check({op_ready, flags, pc}, {1'b1, 6'h00, 22'h0});
      test_ops;
      test_jump;
      test_des;
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      #1;
      check({op_ready, flags, pc, res_kind}, {1'b1, 6'h00, 22'h0, 2'h0});
      test_done;
   end
endmodule // cad_alu_datapath_test
